/* File: hw/icmp_defs.svh */
// Constants for the interrupt controller odd-port programming block
`ifndef ICMP_DEFS_SVH
`define ICMP_DEFS_SVH

// ==========================================
// Vector base word fields
`define ICMP_VEC_BASE_HI     7
`define ICMP_VEC_BASE_LO     3
`define ICMP_VEC_LEVEL_HI    2
`define ICMP_VEC_LEVEL_LO    0

// ==========================================
// Cascade word fields
`define ICMP_CAS_RSV_HI      7
`define ICMP_CAS_RSV_LO      3
`define ICMP_CAS_ENABLE_BIT  2
`define ICMP_CAS_RSV0_BIT    0

// ==========================================
// Mode word fields
`define ICMP_MODE_RSV_HI     7
`define ICMP_MODE_RSV_LO     5
`define ICMP_MODE_NEST_BIT   4
`define ICMP_MODE_BUF_HI     3
`define ICMP_MODE_BUF_LO     2
`define ICMP_MODE_AEOI_BIT   1
`define ICMP_MODE_X86_BIT    0

// ==========================================
// Reset values
`define ICMP_MASK_RESET      8'hff
`define ICMP_WORD_RESET      8'h00

`endif

/* File: hw/icmp_pkg.sv */
// Types for the interrupt controller odd-port programming block
package icmp_pkg;

	typedef enum logic [4:0] {
		ICMP_IDLE     = 5'h01,
		ICMP_WAIT_VEC = 5'h02,
		ICMP_WAIT_CAS = 5'h04,
		ICMP_WAIT_MOD = 5'h08,
		ICMP_READY    = 5'h10
	} icmp_state_type;

	typedef logic [7:0] icmp_byte_type;

endpackage

/* File: hw/icmp_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps

module icmp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1Reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1Reg <= '0;
			dout      <= '0;
		end else begin
			stage1Reg <= din;
			dout      <= stage1Reg;
		end
	end

endmodule

/* File: hw/icmp_init_mask_port.sv */
// Odd-port initialization and mask programming of the interrupt controller
//
// Operation
// R1 - After init starts, odd-port writes load vector base, then cascade, then mode words.
// R2 - Bits 7-3 of the vector base word form the upper bits of every delivered vector.
// R3 - Software writes zero into bits 2-0 of the vector base word.
// R4 - Bit 2 of the cascade word enables cascaded operation.
// R5 - Software writes zero into bits 7-3 and bit 0 of the cascade word.
// R6 - Software writes zero into bits 7-5 of the mode word.
// R7 - Mode bit 4 selects ordinary nesting (0) or special fully nested mode (1).
// R8 - Software sets mode bits 3-2 to 00, non-buffered operation only.
// R9 - Mode bit 1 selects explicit end_of_interrupt (0) or automatic end (1).
// R10 - Mode bit 0 selects the older 8-bit acknowledge (0) or x86 vectored acknowledge (1).
// R11 - Each mask bit gates its request line, 0 enabling it, bit 7 for line 7.
// R12 - After init, odd-port writes update the mask byte and reads return it.
`timescale 1ns/100ps
`include "icmp_defs.svh"

module icmp_init_mask_port (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// Host odd-port access, one-cycle strobes from the decoder
	input  wire logic                   initStart,
	input  wire logic                   oddWrite,
	input  wire logic                   oddRead,
	input  wire icmp_pkg::icmp_byte_type writeData,
	output icmp_pkg::icmp_byte_type     readData,
	// Request lines from pins
	input  wire logic [7:0]             irqPin,
	// Interrupt level being acknowledged
	input  wire logic [2:0]             ackLevel,
	// Decoded configuration
	output icmp_pkg::icmp_byte_type     vectorOut,
	output logic                        cascadeEnable,
	output logic                        specialNested,
	output logic                        autoEoi,
	output logic                        x86Mode,
	output logic                        initDone,
	output logic                        badWriteSeen,
	output logic [7:0]                  maskedRequest
);
	import icmp_pkg::*;

	icmp_state_type state_reg;
	icmp_state_type state_next;
	icmp_byte_type  vector_base_word_reg;
	icmp_byte_type  cascade_config_word_reg;
	icmp_byte_type  operating_mode_word_reg;
	icmp_byte_type  request_mask_byte_reg;
	logic [7:0]     irqSync;
	logic           writeTaken;

	// ==========================================
	// Pin synchronisers
	// Request pins are asynchronous, so two flops stand before the gate
	icmp_sync #(.WIDTH(8)) uSync (
		.clk    (clk),
		.resetn (resetn),
		.din    (irqPin),
		.dout   (irqSync)
	);

	// ==========================================
	// Write acceptance
	// A write in the same cycle as initStart is refused
	assign writeTaken = oddWrite && !initStart;

	// ==========================================
	// Initialization sequencer
	always_comb begin
		state_next = state_reg;
		if (initStart) begin
			state_next = ICMP_WAIT_VEC;
		end else if (oddWrite) begin
			// R1 - write order
			case (state_reg)
				ICMP_WAIT_VEC: state_next = ICMP_WAIT_CAS;
				ICMP_WAIT_CAS: state_next = ICMP_WAIT_MOD;
				ICMP_WAIT_MOD: state_next = ICMP_READY;
				ICMP_IDLE:     state_next = ICMP_IDLE;
				ICMP_READY:    state_next = ICMP_READY;
				default:       state_next = ICMP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ICMP_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Initialization words
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vector_base_word_reg <= `ICMP_WORD_RESET;
		end else if (writeTaken && state_reg == ICMP_WAIT_VEC) begin
			// R1 - first word
			vector_base_word_reg <= writeData;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cascade_config_word_reg <= `ICMP_WORD_RESET;
		end else if (writeTaken && state_reg == ICMP_WAIT_CAS) begin
			// R1 - second word
			cascade_config_word_reg <= writeData;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			operating_mode_word_reg <= `ICMP_WORD_RESET;
		end else if (writeTaken && state_reg == ICMP_WAIT_MOD) begin
			// R1 - third word
			operating_mode_word_reg <= writeData;
		end
	end

	// ==========================================
	// Reserved-bit monitor, sticky until next init
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			badWriteSeen <= 1'b0;
		end else if (writeTaken && (
				// R3 - level field zero
				(state_reg == ICMP_WAIT_VEC &&
					writeData[`ICMP_VEC_LEVEL_HI:`ICMP_VEC_LEVEL_LO] != 3'h0) ||
				// R5 - cascade reserved zero
				(state_reg == ICMP_WAIT_CAS &&
					(writeData[`ICMP_CAS_RSV_HI:`ICMP_CAS_RSV_LO] != 5'h00 ||
					writeData[`ICMP_CAS_RSV0_BIT] != 1'b0)) ||
				// R6 R8 - mode reserved and buffer zero
				(state_reg == ICMP_WAIT_MOD &&
					(writeData[`ICMP_MODE_RSV_HI:`ICMP_MODE_RSV_LO] != 3'h0 ||
					writeData[`ICMP_MODE_BUF_HI:`ICMP_MODE_BUF_LO] != 2'h0)))) begin
			badWriteSeen <= 1'b1;
		end else if (initStart) begin
			badWriteSeen <= 1'b0;
		end
	end

	// ==========================================
	// Mask byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// All lines masked until software opens them
			request_mask_byte_reg <= `ICMP_MASK_RESET;
		end else if (writeTaken && state_reg == ICMP_READY) begin
			// R12 - mask update
			request_mask_byte_reg <= writeData;
		end
	end

	// Read data stands until the next read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readData <= `ICMP_WORD_RESET;
		end else if (oddRead) begin
			// R12 - mask readback
			readData <= request_mask_byte_reg;
		end
	end

	// ==========================================
	// Request gating
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : gGate
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					maskedRequest[gi] <= 1'b0;
				end else begin
					// R11 - zero enables
					maskedRequest[gi] <= irqSync[gi] & ~request_mask_byte_reg[gi];
				end
			end
		end
	endgenerate

	// ==========================================
	// Vector and mode outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vectorOut <= `ICMP_WORD_RESET;
		end else begin
			// R2 - vector base upper bits
			vectorOut <= {vector_base_word_reg[`ICMP_VEC_BASE_HI:`ICMP_VEC_BASE_LO], ackLevel};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cascadeEnable <= 1'b0;
		end else begin
			// R4 - cascade enable
			cascadeEnable <= cascade_config_word_reg[`ICMP_CAS_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			specialNested <= 1'b0;
			autoEoi       <= 1'b0;
			x86Mode       <= 1'b0;
		end else begin
			// R7 - nesting select
			specialNested <= operating_mode_word_reg[`ICMP_MODE_NEST_BIT];
			// R9 - end of interrupt select
			autoEoi       <= operating_mode_word_reg[`ICMP_MODE_AEOI_BIT];
			// R10 - acknowledge protocol
			x86Mode       <= operating_mode_word_reg[`ICMP_MODE_X86_BIT];
		end
	end

	// Done one edge after the mode word lands, low again on a new start
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			initDone <= 1'b0;
		end else begin
			// R1 - sequence complete
			initDone <= (state_reg == ICMP_READY);
		end
	end

endmodule

/* File: bench/icmp_host_model.sv */
// Host processor model driving odd-port cycles
`timescale 1ns/100ps
module icmp_host_model (
	// Clock and read data
	input  wire logic                    clk,
	input  wire icmp_pkg::icmp_byte_type readData,
	// Strobes and write data
	output logic                         initStart,
	output logic                         oddWrite,
	output logic                         oddRead,
	output icmp_pkg::icmp_byte_type      writeData
);
	import icmp_pkg::*;
	initial {initStart, oddWrite, oddRead, writeData} <= 11'h000;
	task automatic pulseWr(input icmp_byte_type d);
		oddWrite <= 1'b1;
		writeData <= d;
		@(posedge clk);
		oddWrite <= 1'b0;
		writeData <= ~d;
		@(posedge clk);
	endtask
	task automatic rd(output icmp_byte_type d);
		oddRead <= 1'b1;
		@(posedge clk);
		oddRead <= 1'b0;
		@(posedge clk);
		d = readData;
	endtask
	task automatic init(input icmp_byte_type v, c, m, input logic clean);
		initStart <= 1'b1;
		@(posedge clk);
		initStart <= 1'b0;
		pulseWr(clean ? v & 8'hf8 : v);
		pulseWr(clean ? c & 8'h04 : c);
		pulseWr(clean ? m & 8'h13 : m);
	endtask
endmodule

/* File: bench/icmp_asserts.sv */
// Port checker of the odd-port programming block
`timescale 1ns/100ps
module icmp_asserts (
	// Clock, reset and host access
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       initStart,
	input wire logic       oddWrite,
	input wire logic       oddRead,
	input wire logic [7:0] writeData,
	input wire logic [7:0] readData,
	// Requests and configuration
	input wire logic [7:0] irqPin,
	input wire logic [2:0] ackLevel,
	input wire logic [7:0] vectorOut,
	input wire logic       cascadeEnable,
	input wire logic       specialNested,
	input wire logic       autoEoi,
	input wire logic       x86Mode,
	input wire logic       initDone,
	input wire logic       badWriteSeen,
	input wire logic [7:0] maskedRequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_vlow; $past(resetn) |-> vectorOut[2:0] == $past(ackLevel); endproperty
	property p_vbase; $changed(vectorOut[7:3]) |->
		vectorOut[7:3] == $past(writeData[7:3], 2); endproperty
	property p_cas; $rose(cascadeEnable) |-> $past(writeData[2], 2); endproperty
	property p_nest; $rose(specialNested) |-> $past(writeData[4], 2); endproperty
	property p_eoi; $rose(autoEoi) |-> $past(writeData[1], 2); endproperty
	property p_x86; $rose(x86Mode) |-> $past(writeData[0], 2); endproperty
	property p_mask; (maskedRequest & ~$past(irqPin, 3)) == 8'h00; endproperty
	property p_read; !$past(oddRead) |-> $stable(readData); endproperty
	sequence s_initReq; initStart; endsequence
	sequence s_doneRise; $rose(initDone); endsequence
	property p_initClr; s_initReq |-> ##2 !initDone; endproperty
	property p_initSet; s_doneRise |-> $past(oddWrite, 2); endproperty
	property p_bad; $rose(badWriteSeen) |-> $past(oddWrite) && !$past(initStart); endproperty
	a_vlow: assert property (p_vlow) else $error("vector low bits");
	a_vbase: assert property (p_vbase) else $error("vector base bits");
	a_cas: assert property (p_cas) else $error("cascade flag");
	a_nest: assert property (p_nest) else $error("nesting flag");
	a_eoi: assert property (p_eoi) else $error("auto end flag");
	a_x86: assert property (p_x86) else $error("x86 flag");
	a_mask: assert property (p_mask) else $error("masked request");
	a_read: assert property (p_read) else $error("read data moved");
	a_initClr: assert property (p_initClr) else $error("done not cleared");
	a_initSet: assert property (p_initSet) else $error("done without mode write");
	a_bad: assert property (p_bad) else $error("reserved flag without write");
endmodule
bind icmp_init_mask_port icmp_asserts u_chk (
	.clk           (clk),
	.resetn        (resetn),
	.initStart     (initStart),
	.oddWrite      (oddWrite),
	.oddRead       (oddRead),
	.writeData     (writeData),
	.readData      (readData),
	.irqPin        (irqPin),
	.ackLevel      (ackLevel),
	.vectorOut     (vectorOut),
	.cascadeEnable (cascadeEnable),
	.specialNested (specialNested),
	.autoEoi       (autoEoi),
	.x86Mode       (x86Mode),
	.initDone      (initDone),
	.badWriteSeen  (badWriteSeen),
	.maskedRequest (maskedRequest)
);

/* File: bench/icmp_init_mask_port_bench.sv */
// Self-checking bench of the odd-port programming block
`timescale 1ns/100ps
module icmp_init_mask_port_bench;
	import icmp_pkg::*;
	// Vector, cascade, mode, mask, expected flags
	localparam logic [39:0] TAB [2] = '{40'ha8_04_13_3f_1f, 40'h50_80_00_80_30};
	logic clk, resetn, initStart, oddWrite, oddRead, initDone, badWriteSeen;
	logic cascadeEnable, specialNested, autoEoi, x86Mode;
	logic [7:0] irqPin, maskedRequest, writeData, readData, vectorOut, got;
	logic [2:0] ackLevel;
	int fails, samplesChecked;
	wire [7:0] flg = {2'h0, badWriteSeen, initDone, cascadeEnable, specialNested, autoEoi, x86Mode};
	icmp_host_model host (
		.clk       (clk),
		.readData  (readData),
		.initStart (initStart),
		.oddWrite  (oddWrite),
		.oddRead   (oddRead),
		.writeData (writeData)
	);
	icmp_init_mask_port uut (
		.clk           (clk),
		.resetn        (resetn),
		.initStart     (initStart),
		.oddWrite      (oddWrite),
		.oddRead       (oddRead),
		.writeData     (writeData),
		.readData      (readData),
		.irqPin        (irqPin),
		.ackLevel      (ackLevel),
		.vectorOut     (vectorOut),
		.cascadeEnable (cascadeEnable),
		.specialNested (specialNested),
		.autoEoi       (autoEoi),
		.x86Mode       (x86Mode),
		.initDone      (initDone),
		.badWriteSeen  (badWriteSeen),
		.maskedRequest (maskedRequest)
	);
	initial clk = 1'b0;
	always #20 clk = ~clk;
	task automatic chk(input string n, input logic [7:0] e, g);
		samplesChecked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("checked %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		{resetn, irqPin, ackLevel} <= {1'b0, 8'hff, 3'h5};
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("masked at reset", 8'h00, maskedRequest);
		host.pulseWr(8'h00);
		host.rd(got);
		chk("mask before init", 8'hff, got);
		for (int i = 0; i < 2; i++) begin
			host.init(TAB[i][39:32], TAB[i][31:24], TAB[i][23:16], i == 0);
			repeat (2) @(posedge clk);
			chk("vector", TAB[i][39:32] & 8'hf8 | 8'h05, vectorOut);
			chk("flags", TAB[i][7:0], flg);
			host.pulseWr(TAB[i][15:8]);
			host.rd(got);
			chk("mask read", TAB[i][15:8], got);
			repeat (3) @(posedge clk);
			chk("masked requests", ~TAB[i][15:8], maskedRequest);
		end
		irqPin <= 8'h96;
		ackLevel <= 3'h2;
		repeat (4) @(posedge clk);
		chk("pin gating", 8'h16, maskedRequest);
		chk("vector level", 8'h52, vectorOut);
		conclude();
	end
endmodule
